// ==== design/tweep_core.sv ====
// two-wire serial eeprom target: link engine, page buffer, array
// assumes pads resolve sda wired-and and pull floating straps low
`timescale 1ns/100ps
module tweep_core
  import tweep_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = WR_CYCLES
)(
  // core clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  // two-wire bus
  input  wire logic       scl,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // straps
  input  wire logic [2:0] strapAddressPins,
  input  wire logic       writeProtect,
  // status
  output logic            writeBusy
);

  // ****************************************
  // core domain: pin filters
  // ****************************************
  tweep_bus_s pin1_r, pin2_r, pin3_r, busF_r, busNxt;
  tweep_cfg_s cfg1_r, cfg2_r, cfg3_r, cfgF_r;
  logic       linkRst_r, stopSeen_r, busy_r;
  logic       wrTag_r, wrTag1_r, wrTagS_r, doneTag_r;
  logic [PROG_W-1:0] progCnt_r;

  // floating pins arrive low through pad pull-downs
  wire tweep_cfg_s cfgIn = '{wp: writeProtect, strap: strapAddressPins};
  wire busAgree = (pin2_r == pin3_r);
  wire cfgAgree = (cfg2_r == cfg3_r);
  assign busNxt = busAgree ? pin3_r : busF_r;
  wire startEv  = busF_r.scl & busNxt.scl & busF_r.sda & ~busNxt.sda;
  wire stopEv   = busF_r.scl & busNxt.scl & ~busF_r.sda & busNxt.sda;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin1_r <= '0;
      pin2_r <= '0;
      pin3_r <= '0;
      busF_r <= '0;
      cfg1_r <= '0;
      cfg2_r <= '0;
      cfg3_r <= '0;
      cfgF_r <= '0;
    end
    else
    begin
      pin1_r <= '{scl: scl, sda: sdaIn};
      pin2_r <= pin1_r;
      pin3_r <= pin2_r;
      busF_r <= busNxt;
      cfg1_r <= cfgIn;
      cfg2_r <= cfg1_r;
      cfg3_r <= cfg2_r;
      cfgF_r <= cfgAgree ? cfg3_r : cfgF_r;
    end
  end

  // ****************************************
  // core domain: framing and programming
  // ****************************************
  // link logic held idle from start/stop until scl is seen low,
  // so after start/stop its reset releases in a low phase of the clock; after arst_n it releases on the next core clock
  wire linkRstNxt = (startEv | stopEv) ? 1'b1 : (busF_r.scl & linkRst_r);
  wire pending    = (wrTagS_r != doneTag_r);
  wire commitGo   = stopSeen_r & pending & ~busy_r;
  wire progEnd    = busy_r & (progCnt_r == PROG_W'(WRITE_CYCLES - 1));
  wire [PAGE_W-1:0] slot = progCnt_r[PAGE_W-1:0];
  logic [PAGE_BYTES-1:0] pageMask_r;
  logic [ADDR_W-1:0]     memAddr_r;
  wire memWe = busy_r & (progCnt_r < PROG_W'(PAGE_BYTES)) & pageMask_r[slot];

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      linkRst_r  <= 1'b1;
      stopSeen_r <= 1'b0;
      wrTag1_r   <= 1'b0;
      wrTagS_r   <= 1'b0;
      doneTag_r  <= 1'b0;
      busy_r     <= 1'b0;
      progCnt_r  <= PROG_RST;
    end
    else
    begin
      linkRst_r  <= linkRstNxt;
      stopSeen_r <= stopEv;
      wrTag1_r   <= wrTag_r;
      wrTagS_r   <= wrTag1_r;
      doneTag_r  <= commitGo ? wrTagS_r : doneTag_r;
      // protected writes are dropped, never programmed
      busy_r     <= (commitGo & ~cfgF_r.wp) | (busy_r & ~progEnd);
      // self-timed, bounded by the write cycle count
      progCnt_r  <= busy_r ? progCnt_r + 1'b1 : PROG_RST;
    end
  end

  assign writeBusy = busy_r;

  // ****************************************
  // array
  // ****************************************
  logic [7:0] memArr [MEM_BYTES];
  logic [7:0] pageBuf [PAGE_BYTES];

  // only marked bytes are programmed, so partial pages work
  always_ff @(posedge clock)
  begin
    if (memWe)
      memArr[{memAddr_r[ADDR_W-1:PAGE_W], slot}] <= pageBuf[slot];
  end

  // ****************************************
  // link domain: engine
  // ****************************************
  wire linkRstN = arst_n & ~linkRst_r;
  tweep_state_e state_r, stateNxt;
  logic [3:0] bitCnt_r;
  logic [7:0] shift_r, rdByte_r;
  logic       ackMine_r, gotData_r;
  logic       busy1_r, busyS_r;
  logic [2:0] strap1_r, strapS_r;
  logic       sdaOe_r, sdaOut_r;

  wire [7:0] byteIn = {shift_r[6:0], sdaIn};
  wire byteEnd  = (bitCnt_r == BIT_LAST);
  wire ackSlot  = (bitCnt_r == BIT_ACK);
  wire devMatch = (byteIn[7:4] == DEV_CODE) & (byteIn[3:1] == strapS_r);
  wire devEnd   = (state_r == ST_DEV) & byteEnd;
  wire devHit   = devEnd & devMatch & ~busyS_r;
  wire rdStart  = devHit & byteIn[0];
  wire ahiEnd   = (state_r == ST_AHI) & byteEnd;
  wire aloEnd   = (state_r == ST_ALO) & byteEnd;
  wire datEnd   = (state_r == ST_WDAT) & byteEnd;
  wire rdAckTm  = (state_r == ST_RDAT) & ackSlot & ~ackMine_r;
  wire rdNext   = rdAckTm & ~sdaIn;
  wire doAck    = devHit | ahiEnd | aloEnd | datEnd;
  // sequential reads wrap over the whole array, writes within a page
  wire [ADDR_W-1:0] addrInc = memAddr_r + 1'b1;
  wire [ADDR_W-1:0] pageInc = {memAddr_r[ADDR_W-1:PAGE_W], addrInc[PAGE_W-1:0]};

  always_comb
  begin
    stateNxt = state_r;
    unique case (state_r)
      ST_DEV:  if (devEnd) stateNxt = !devHit ? ST_IDLE : (byteIn[0] ? ST_RDAT : ST_AHI);
      ST_AHI:  if (byteEnd) stateNxt = ST_ALO;
      ST_ALO:  if (byteEnd) stateNxt = ST_WDAT;
      ST_WDAT: stateNxt = ST_WDAT;
      ST_RDAT: if (rdAckTm & sdaIn) stateNxt = ST_IDLE;
      ST_IDLE: stateNxt = ST_IDLE;
      default: stateNxt = ST_IDLE;
    endcase
  end

  // quasi-static levels into the link domain
  always_ff @(posedge scl or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy1_r  <= 1'b0;
      busyS_r  <= 1'b0;
      strap1_r <= '0;
      strapS_r <= '0;
    end
    else
    begin
      busy1_r  <= busy_r;
      busyS_r  <= busy1_r;
      strap1_r <= cfgF_r.strap;
      strapS_r <= strap1_r;
    end
  end

  // sample on the rising bus clock edge
  always_ff @(posedge scl or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      state_r   <= ST_DEV;
      bitCnt_r  <= BIT_RST;
      shift_r   <= '0;
      ackMine_r <= 1'b0;
      gotData_r <= 1'b0;
    end
    else
    begin
      state_r   <= stateNxt;
      bitCnt_r  <= ackSlot ? BIT_RST : bitCnt_r + 1'b1;
      shift_r   <= ackSlot ? shift_r : byteIn;
      ackMine_r <= ackSlot ? 1'b0 : (byteEnd ? doAck : ackMine_r);
      gotData_r <= (gotData_r | datEnd) & ~aloEnd;
    end
  end

  // address, page buffer and write tag survive across frames
  always_ff @(posedge scl or negedge arst_n)
  begin
    if (!arst_n)
    begin
      memAddr_r  <= ADDR_RST;
      pageMask_r <= '0;
      wrTag_r    <= 1'b0;
    end
    else
    begin
      if (ahiEnd)
        memAddr_r[ADDR_W-1:8] <= byteIn[ADDR_W-9:0];
      else if (aloEnd)
        memAddr_r[7:0] <= byteIn;
      else if (datEnd)
        memAddr_r <= pageInc;
      else if (rdStart | rdNext)
        memAddr_r <= addrInc;
      if (aloEnd)
        pageMask_r <= '0;
      else if (datEnd)
        pageMask_r[memAddr_r[PAGE_W-1:0]] <= 1'b1;
      wrTag_r <= wrTag_r ^ (datEnd & ~gotData_r);
    end
  end

  // array read is safe: the core never programs while an acknowledged frame runs
  always_ff @(posedge scl)
  begin
    if (datEnd)
      pageBuf[memAddr_r[PAGE_W-1:0]] <= byteIn;
    if (rdStart | rdNext)
      rdByte_r <= memArr[memAddr_r];
  end

  // ****************************************
  // link domain: open-drain driver
  // ****************************************
  wire rdBitLow = (state_r == ST_RDAT) & ~ackSlot & ~rdByte_r[~bitCnt_r[2:0]];

  // drive changes on the falling edge, low or released only
  always_ff @(negedge scl or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      sdaOe_r  <= 1'b0;
      sdaOut_r <= 1'b0;
    end
    else
    begin
      sdaOe_r  <= (ackSlot & ackMine_r) | rdBitLow;
      sdaOut_r <= 1'b0;
    end
  end

  assign sdaOe  = sdaOe_r;
  assign sdaOut = sdaOut_r;

  // ****************************************
  // checks
  // ****************************************
  chk_wp_block: assert property (@(posedge clock) disable iff (!arst_n)
    (commitGo && cfgF_r.wp) |=> !busy_r ##1 !busy_r)
    else $error("protected write started programming");
  chk_prog_go: assert property (@(posedge clock) disable iff (!arst_n)
    (commitGo && !cfgF_r.wp) |=> busy_r ##1 busy_r)
    else $error("unprotected write not programmed");
  chk_busy_len: assert property (@(posedge clock) disable iff (!arst_n)
    $fell(busy_r) |-> $past(progCnt_r) == PROG_W'(WRITE_CYCLES - 1))
    else $error("programming time wrong");
  chk_we_page: assert property (@(posedge clock) disable iff (!arst_n)
    memWe |-> progCnt_r < PROG_W'(PAGE_BYTES))
    else $error("array write outside page sweep");
  chk_od_low: assert property (@(posedge clock) disable iff (!arst_n)
    sdaOut == 1'b0)
    else $error("data line driven high");
  chk_busy_nack: assert property (@(posedge scl) disable iff (!linkRstN)
    (devEnd && busyS_r) |=> !ackMine_r && state_r == ST_IDLE)
    else $error("request accepted while busy");
  chk_addr_ack: assert property (@(posedge scl) disable iff (!linkRstN)
    (devEnd && devMatch && !busyS_r) |=> ackMine_r && sdaOe_r)
    else $error("matching address not acknowledged");
  chk_addr_miss: assert property (@(posedge scl) disable iff (!linkRstN)
    (devEnd && byteIn[3:1] != strapS_r) |=> state_r == ST_IDLE && !ackMine_r)
    else $error("foreign address accepted");
  chk_rd_drive: assert property (@(posedge scl) disable iff (!linkRstN)
    (state_r == ST_RDAT && !ackSlot) |-> sdaOe_r == rdBitLow)
    else $error("read bit not set up while clock low");
  chk_page_wrap: assert property (@(posedge scl) disable iff (!linkRstN)
    datEnd |=> memAddr_r[ADDR_W-1:PAGE_W] == $past(memAddr_r[ADDR_W-1:PAGE_W]))
    else $error("page write left its page");

  cov_program: cover property (@(posedge clock) disable iff (!arst_n)
    commitGo && !cfgF_r.wp);
  cov_wp_drop: cover property (@(posedge clock) disable iff (!arst_n)
    commitGo && cfgF_r.wp);
  cov_rd_seq: cover property (@(posedge scl) disable iff (!linkRstN) rdNext);
  cov_busy_nack: cover property (@(posedge scl) disable iff (!linkRstN)
    devEnd && devMatch && busyS_r);

endmodule : tweep_core

// ==== design/tweep_pkg.sv ====
// two-wire eeprom pin interface: sizes, timing, states, carriers
// assumes a 20 MHz core clock and a link side run by the bus clock
package tweep_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int ADDR_W     = 15;
  localparam int MEM_BYTES  = 32768;
  localparam int PAGE_BYTES = 64;
  localparam int PAGE_W     = 6;
  localparam int PROG_W     = 17;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned WR_TIME_US = 5000;
  // longest time, so integer division rounds down
  localparam int unsigned WR_CYCLES  = WR_TIME_US * (CLK_HZ / 1_000_000);

  // ****************************************
  // link framing
  // ****************************************
  localparam logic [3:0] DEV_CODE = 4'ha;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK  = 4'h8;
  localparam logic [3:0] BIT_RST  = 4'h0;
  localparam logic [PROG_W-1:0] PROG_RST = 17'h0_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;

  typedef enum logic [2:0] {
    ST_DEV  = 3'b000,
    ST_AHI  = 3'b001,
    ST_ALO  = 3'b010,
    ST_WDAT = 3'b011,
    ST_RDAT = 3'b100,
    ST_IDLE = 3'b101
  } tweep_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } tweep_bus_s;

  typedef struct packed {
    logic       wp;
    logic [2:0] strap;
  } tweep_cfg_s;

endpackage : tweep_pkg

// ==== testbench/tweep_ctl_model.sv ====
// bus controller model: drives bus clock and open-drain data
// assumes the bench resolves the data line with a pull-up
`timescale 1ns/100ps
module tweep_ctl_model
  import tweep_pkg::*;
(
  // core clock
  input  wire logic       clock,
  // bus
  input  wire logic       sdaIn,
  output logic            scl,
  output logic            sdaOe,
  // results
  output logic [8:0]      res,
  output logic            resStb
);
  initial
  begin
    scl = 1'b1;
    sdaOe = 1'b0;
    res = 9'h000;
    resStb = 1'b0;
  end

  // half period of 10 core clocks, 1 MHz bus clock
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // also serves as repeated start
  task automatic start();
    sdaOe <= 1'b0;
    tick(5);
    scl <= 1'b1;
    tick(10);
    sdaOe <= 1'b1;
    tick(10);
    scl <= 1'b0;
    tick(5);
  endtask : start

  task automatic stop();
    sdaOe <= 1'b1;
    tick(5);
    scl <= 1'b1;
    tick(10);
    sdaOe <= 1'b0;
    tick(20);
  endtask : stop

  // data changes mid-low, sampled mid-high; mAck high pulls the ninth bit
  task automatic xfer(input logic [7:0] d, input logic mAck);
    logic [8:0] w;
    logic [8:0] r;
    w = {~d, mAck};
    for (int i = 8; i >= 0; i--)
    begin
      sdaOe <= w[i];
      tick(5);
      scl <= 1'b1;
      tick(5);
      r[i] = sdaIn;
      tick(5);
      scl <= 1'b0;
      tick(5);
    end
    res <= {r[0], r[8:1]};
    resStb <= 1'b1;
    tick(1);
    resStb <= 1'b0;
  endtask : xfer
endmodule : tweep_ctl_model

// ==== testbench/two_wire_eeprom_pin_interface_tb.sv ====
// bench for the eeprom pin interface: model controller plus scoreboard
// assumes pull-up on data; floating straps and protect modelled as 0
`timescale 1ns/100ps
module two_wire_eeprom_pin_interface_tb;
  import tweep_pkg::*;
  // short write time keeps the run brief
  localparam int unsigned WC = 400;
  logic        clock;
  logic        arst_n = 1'b1;
  logic        scl;
  logic        sdaIn;
  logic        sdaOut;
  logic        sdaOe;
  logic        mOe;
  logic        wp;
  logic        busy;
  logic        stb;
  logic [2:0]  strap;
  logic [8:0]  res;
  logic [14:0] base;
  logic [31:0] seed = 32'ha04d_8cd1;
  logic [8:0]  expq[$];
  logic [7:0]  mem[int];
  int          n_fail = 0;
  int          cmp_count = 0;
  int          nBusy = 0;
  int          busyLen = 0;

  // wired-and with pull-up
  assign sdaIn = ~(mOe | (sdaOe & ~sdaOut));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  tweep_core #(.WRITE_CYCLES(WC)) uut (
    .clock            (clock),
    .arst_n           (arst_n),
    .scl              (scl),
    .sdaIn            (sdaIn),
    .sdaOut           (sdaOut),
    .sdaOe            (sdaOe),
    .strapAddressPins (strap),
    .writeProtect     (wp),
    .writeBusy        (busy)
  );

  tweep_ctl_model m (
    .clock  (clock),
    .sdaIn  (sdaIn),
    .scl    (scl),
    .sdaOe  (mOe),
    .res    (res),
    .resStb (stb)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // ****************************************
  // scoreboard
  // ****************************************
  always @(posedge clock)
    if (stb === 1'b1)
      check(res, expq.pop_front());

  always @(posedge clock)
    if (busy === 1'b1)
      busyLen++;
    else if (busyLen != 0)
    begin
      nBusy++;
      check(9'(busyLen), 9'(WC));
      busyLen = 0;
    end

  // ****************************************
  // stimulus
  // ****************************************
  task automatic op(input logic [7:0] d, input logic mAck, input logic [8:0] exp);
    expq.push_back(exp);
    m.xfer(d, mAck);
  endtask : op

  task automatic dev(input logic [2:0] a, input logic rw, input logic ack);
    op({DEV_CODE, a, rw}, 1'b0, {~ack, DEV_CODE, a, rw});
  endtask : dev

  task automatic addr(input logic [14:0] a);
    m.start();
    dev(strap, 1'b0, 1'b1);
    op({1'b0, a[14:8]}, 1'b0, {2'b00, a[14:8]});
    op(a[7:0], 1'b0, {1'b0, a[7:0]});
  endtask : addr

  task automatic wr(input logic [14:0] a, input int n, input logic prog);
    logic [7:0] d;
    addr(a);
    for (int i = 0; i < n; i++)
    begin
      d = 8'(rnd());
      op(d, 1'b0, {1'b0, d});
      if (prog)
        mem[{a[14:6], 6'(a[5:0] + i)}] = d;
    end
    m.stop();
  endtask : wr

  task automatic rd(input logic [14:0] a, input int n);
    addr(a);
    m.start();
    dev(strap, 1'b1, 1'b1);
    for (int i = 0; i < n; i++)
      op(8'hff, i < n - 1, {~(i < n - 1), mem[15'(a + i)]});
    m.stop();
  endtask : rd

  initial
  begin
    // reset falls once every process waits, so no edge is missed
    arst_n <= 1'b0;
    wp     <= 1'b0;
    strap  <= 3'h0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    strap <= 3'(rnd());
    repeat (10) @(posedge clock);
    for (int i = 0; i < 8; i++)
    begin
      m.start();
      dev(3'(i), 1'b0, 3'(i) == strap);
      m.stop();
    end
    $display("strap select test done");
    base = {9'(rnd()), 6'h3e};
    wr(base, 3, 1'b1);
    for (int k = 0; k < 50 && busy !== 1'b1; k++)
      @(posedge clock);
    check(9'(busy), 9'h001);
    m.start();
    dev(strap, 1'b0, 1'b0);
    m.stop();
    for (int k = 0; k < 1000 && busy !== 1'b0; k++)
      @(posedge clock);
    check(9'(busy), 9'h000);
    repeat (10) @(posedge clock);
    check(9'(nBusy), 9'h001);
    $display("page write test done");
    wp <= 1'b1;
    wr(base, 2, 1'b0);
    repeat (50) @(posedge clock);
    check(9'(nBusy), 9'h001);
    wp <= 1'b0;
    $display("protect test done");
    // pointer sits at page start after the wrapped protected write
    m.start();
    dev(strap, 1'b1, 1'b1);
    op(8'hff, 1'b0, {1'b1, mem[{base[14:6], 6'h00}]});
    m.stop();
    rd({base[14:6], 6'h00}, 1);
    rd(base, 2);
    $display("read back test done");
    repeat (5) @(posedge clock);
    check(9'(expq.size()), 9'h000);
    report_and_stop();
  end

  initial
  begin
    repeat (40000) @(posedge clock);
    n_fail++;
    report_and_stop();
  end
endmodule : two_wire_eeprom_pin_interface_tb
